/* File: rtl/ucrx_channel.sv */
// one uart channel: reset state, receive trigger and data-with-status unload
// Operation
// (R1) receive interrupt raised when fifo fill reaches trigger threshold
// (R2) trigger threshold is 8-bit write-only, 0 to 64
// (R3) reset: status 0x01, line status 0x60, scratch 0xff, others zero
// (R4) modem status low bits clear, upper bits follow modem inputs
// (R5) transmit idles high, or low when infrared enable pin high
// (R6) host does a dummy identity read before unloading
// (R7) after identity read, repeated data-with-status reads stay ordered
// (R8) host repeats identity read after touching any other register
// (R9) each data-with-status read gives byte plus its error status
// (R10) host stops when returned line-status bit zero is clear
// (R11) global interrupt register at 0x080, further ones 0x081 to 0x083
// (R12) reset drives request-to-send and terminal-ready high, eeprom pins low
`timescale 1ns/10ps
`default_nettype none
`include "ucrx_defines.svh"
module ucrx_channel
  import ucrx_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic bus_rd_i,
  input wire logic bus_wr_i,
  input wire logic [11:0] bus_addr_i,
  input wire logic [7:0] bus_wdata_i,
  output logic [15:0] bus_rdata_o,
  output logic bus_rvalid_o,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic [7:0] rx_err_i,
  output logic rx_ready_o,
  input wire logic [3:0] modem_in_i,
  input wire logic infrared_enable_pin_i,
  output logic tx_o,
  output logic rts_n_o,
  output logic dtr_n_o,
  output logic eeprom_serial_clock_o,
  output logic eeprom_chip_select_o,
  output logic eeprom_serial_out_o,
  output logic irq_o,
  output logic unload_synced_o
);
  ucrx_bus_req_type req;
  ucrx_rx_word_type fifo_in;
  ucrx_rx_word_type fifo_out;
  ucrx_unload_type unload_r;
  logic [7:0] rx_trigger_threshold_r;
  logic [7:0] irq_status_reg_r;
  logic [7:0] scratch_reg_r;
  logic [3:0] msr_delta_r;
  logic [3:0] modem_prev_r;
  logic [15:0] rdata_nxt;
  logic [15:0] rdata_r;
  logic rvalid_r;
  logic irq_r;
  logic tx_r;
  logic rts_n_r;
  logic dtr_n_r;
  logic in_ready;
  logic out_valid;
  logic pop;
  logic [4:0] fill;
  logic [7:0] fill8;
  logic [7:0] lsr_now;
  logic rx_ready_r;
  logic [4:0] fill_nxt;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction : hit

  assign req = '{rd: bus_rd_i, wr: bus_wr_i, addr: bus_addr_i, wdata: bus_wdata_i};
  assign fifo_in = '{status: rx_err_i, data: rx_byte_i};
  assign fill8 = {3'h0, fill};
  // fill after this edge, so ready can be a plain flop and still never overrun
  assign fill_nxt = fill + 5'(rx_valid_i & rx_ready_r) - 5'(pop);
  assign pop = req.rd & hit(req.addr, `UCRX_OFF_RX_DATA_STAT) & out_valid;
  // data-ready in bit zero, fifo empty flags cleared while data waits, as at reset when empty
  assign lsr_now = out_valid ? (`UCRX_RST_LSR & 8'h9f) | 8'h01 : `UCRX_RST_LSR;

  ucrx_fifo #(
    .WIDTH(16),
    .DEPTH(`UCRX_FIFO_DEPTH),
    .AW(`UCRX_FIFO_AW)
  ) u_fifo (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(rx_valid_i & rx_ready_r),
    .in_ready_o(in_ready),
    .in_data_i(fifo_in),
    .out_valid_o(out_valid),
    .out_ready_i(pop),
    .out_data_o(fifo_out),
    .count_o(fill)
  );

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) rx_trigger_threshold_r <= `UCRX_RST_ZERO; // [R3]
    else if (req.wr && hit(req.addr, `UCRX_OFF_RX_TRIG) && req.wdata <= `UCRX_TRIG_MAX)
      rx_trigger_threshold_r <= req.wdata; // [R2]
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) scratch_reg_r <= `UCRX_RST_SCRATCH; // [R3]
    else if (req.wr && hit(req.addr, `UCRX_OFF_SCRATCH)) scratch_reg_r <= req.wdata;
  end

  // receive interrupt level follows fill against threshold
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      irq_status_reg_r <= `UCRX_RST_ISR; // [R3]
      irq_r <= 1'b0;
    end else if (fill8 >= rx_trigger_threshold_r && fill8 != 8'h00) begin
      irq_status_reg_r <= `UCRX_ISR_RX_TRIG; // [R1]
      irq_r <= 1'b1;
    end else begin
      irq_status_reg_r <= `UCRX_RST_ISR;
      irq_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      msr_delta_r <= 4'h0; // [R4]
      // no false change on the first edge after reset
      modem_prev_r <= modem_in_i;
    end else begin
      modem_prev_r <= modem_in_i;
      // change seen wins over clear by read
      if (req.rd && hit(req.addr, `UCRX_OFF_MSR)) msr_delta_r <= modem_prev_r ^ modem_in_i;
      else msr_delta_r <= msr_delta_r | (modem_prev_r ^ modem_in_i);
    end
  end

  // ordering sync: identity read or write arms, any other access except data-with-status disarms
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) unload_r <= UCRX_UNSYNCED;
    else if (req.rd || req.wr) begin
      if (hit(req.addr, `UCRX_OFF_DEVID_B) || hit(req.addr, `UCRX_OFF_DEVID_D)) unload_r <= UCRX_SYNCED; // [R7]
      else if (!hit(req.addr, `UCRX_OFF_RX_DATA_STAT)) unload_r <= UCRX_UNSYNCED; // [R8]
    end
  end

  always_comb begin
    rdata_nxt = 16'h0000;
    unique case (req.addr)
      `UCRX_OFF_GLOBAL_IRQ: rdata_nxt = {15'h0000, irq_r}; // [R11]
      `UCRX_OFF_MAP_A: rdata_nxt = {8'h00, irq_status_reg_r};
      `UCRX_OFF_MAP_B: rdata_nxt = 16'h0000;
      `UCRX_OFF_MAP_C: rdata_nxt = 16'h0000;
      `UCRX_OFF_DEVID_B: rdata_nxt = {8'h00, `UCRX_DEVID_VAL}; // [R6]
      `UCRX_OFF_DEVID_D: rdata_nxt = {`UCRX_DEVID_VAL, 8'h00};
      `UCRX_OFF_RX_DATA_STAT: rdata_nxt = out_valid ? {fifo_out.status | 8'h01, fifo_out.data}
                                                    : {lsr_now, 8'h00}; // [R9] [R10]
      `UCRX_OFF_ISR: rdata_nxt = {8'h00, irq_status_reg_r};
      `UCRX_OFF_LSR: rdata_nxt = {8'h00, lsr_now};
      `UCRX_OFF_MSR: rdata_nxt = {8'h00, modem_in_i, msr_delta_r}; // [R4]
      `UCRX_OFF_SCRATCH: rdata_nxt = {8'h00, scratch_reg_r};
      `UCRX_OFF_RX_CNT: rdata_nxt = {8'h00, fill8};
      default: rdata_nxt = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rdata_r <= 16'h0000;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= req.rd;
      if (req.rd) rdata_r <= rdata_nxt;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      tx_r <= ~infrared_enable_pin_i; // [R5]
      rts_n_r <= 1'b1; // [R12]
      dtr_n_r <= 1'b1; // [R12]
    end else begin
      tx_r <= ~infrared_enable_pin_i; // [R5]
      rts_n_r <= 1'b1;
      dtr_n_r <= 1'b1;
    end
  end

  logic ee_r;
  always_ff @(posedge clk_sys_i) begin
    ee_r <= 1'b0; // [R12]
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) rx_ready_r <= 1'b0;
    else rx_ready_r <= (fill_nxt < 5'(`UCRX_FIFO_DEPTH));
  end

  assign bus_rdata_o = rdata_r;
  assign bus_rvalid_o = rvalid_r;
  assign rx_ready_o = rx_ready_r;
  assign tx_o = tx_r;
  assign rts_n_o = rts_n_r;
  assign dtr_n_o = dtr_n_r;
  assign eeprom_serial_clock_o = ee_r;
  assign eeprom_chip_select_o = ee_r;
  assign eeprom_serial_out_o = ee_r;
  assign irq_o = irq_r;
  assign unload_synced_o = (unload_r == UCRX_SYNCED);
endmodule : ucrx_channel
`default_nettype wire

/* File: rtl/ucrx_defines.svh */
// constants for the uart channel receive-unload block
`ifndef UCRX_DEFINES_SVH
`define UCRX_DEFINES_SVH
`define UCRX_ADDR_W 12
`define UCRX_OFF_GLOBAL_IRQ 12'h080
`define UCRX_OFF_MAP_A 12'h081
`define UCRX_OFF_MAP_B 12'h082
`define UCRX_OFF_MAP_C 12'h083
`define UCRX_OFF_DEVID_B 12'h08d
`define UCRX_OFF_DEVID_D 12'h08c
`define UCRX_OFF_RX_DATA_STAT 12'h180
`define UCRX_OFF_RX_TRIG 12'h0a0
`define UCRX_OFF_ISR 12'h0a1
`define UCRX_OFF_LSR 12'h0a2
`define UCRX_OFF_MSR 12'h0a3
`define UCRX_OFF_SCRATCH 12'h0a4
`define UCRX_OFF_RX_CNT 12'h0a5
`define UCRX_RST_ISR 8'h01
`define UCRX_RST_LSR 8'h60
`define UCRX_RST_SCRATCH 8'hff
`define UCRX_RST_ZERO 8'h00
`define UCRX_ISR_RX_TRIG 8'h04
`define UCRX_TRIG_MAX 8'h40
`define UCRX_DEVID_VAL 8'h5a
`define UCRX_FIFO_DEPTH 16
`define UCRX_FIFO_AW 4
`endif

/* File: rtl/ucrx_pkg.sv */
// types for the uart channel receive-unload block
package ucrx_pkg;
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] data;
  } ucrx_rx_word_type;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [7:0] wdata;
  } ucrx_bus_req_type;
  typedef enum logic [1:0] {UCRX_UNSYNCED, UCRX_SYNCED} ucrx_unload_type;
endpackage : ucrx_pkg

/* File: rtl/ucrx_fifo.sv */
// parameterised valid/ready fifo for received words
`timescale 1ns/10ps
`default_nettype none
module ucrx_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic [AW:0] count_o
);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;
  assign in_ready_o = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o = mem_r[rp_r];
  assign count_o = cnt_r;
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem_r[wp_r] <= in_data_i;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + AW'(1);
      if (pop) rp_r <= rp_r + AW'(1);
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : ucrx_fifo
`default_nettype wire

/* File: test/ucrx_asserts.sv */
// assertions on the uart channel ports
`timescale 1ns/10ps
`default_nettype none
module ucrx_asserts (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic bus_rd_i,
  input wire logic bus_wr_i,
  input wire logic [11:0] bus_addr_i,
  input wire logic [15:0] bus_rdata_o,
  input wire logic bus_rvalid_o,
  input wire logic infrared_enable_pin_i,
  input wire logic tx_o,
  input wire logic rts_n_o,
  input wire logic dtr_n_o,
  input wire logic eeprom_serial_clock_o,
  input wire logic eeprom_chip_select_o,
  input wire logic eeprom_serial_out_o,
  input wire logic irq_o,
  input wire logic unload_synced_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_rd(a);
    bus_rd_i && bus_addr_i == a;
  endsequence
  property p_ans; bus_rd_i |=> bus_rvalid_o; endproperty
  property p_quiet; !bus_rd_i |=> !bus_rvalid_o && $stable(bus_rdata_o); endproperty
  property p_rst; $fell(sys_rst_i) |-> tx_o && rts_n_o && dtr_n_o && !eeprom_chip_select_o; endproperty
  property p_idle; 1'b1 |=> tx_o == !$past(infrared_enable_pin_i); endproperty
  property p_pins; rts_n_o && dtr_n_o && !eeprom_serial_clock_o && !eeprom_serial_out_o; endproperty
  property p_sync; s_rd(12'h08d) |=> unload_synced_o; endproperty
  property p_desync;
    (bus_rd_i || bus_wr_i) && !(bus_addr_i inside {12'h08c, 12'h08d, 12'h180}) |=> !unload_synced_o;
  endproperty
  property p_empty; s_rd(12'h180) ##1 !bus_rdata_o[8] |-> bus_rdata_o == 16'h6000; endproperty
  property p_glob; s_rd(12'h080) |=> bus_rdata_o[0] == $past(irq_o); endproperty
  a_ans: assert property (p_ans) else $error("no read answer");
  a_quiet: assert property (p_quiet) else $error("read data moved");
  a_rst: assert property (p_rst) else $error("reset pin state");
  a_idle: assert property (p_idle) else $error("tx idle level");
  a_pins: assert property (p_pins) else $error("modem or eeprom pins");
  a_sync: assert property (p_sync) else $error("identity read not seen");
  a_desync: assert property (p_desync) else $error("sync kept");
  a_empty: assert property (p_empty) else $error("empty word");
  a_glob: assert property (p_glob) else $error("global irq bit");
endmodule : ucrx_asserts
bind ucrx_channel ucrx_asserts chk_u (.*);
`default_nettype wire

/* File: test/ucrx_rx_src.sv */
// receive byte source in place of the serial line engine
`timescale 1ns/10ps
`default_nettype none
module ucrx_rx_src (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic go_i,
  input wire logic [7:0] n_i,
  input wire logic ready_i,
  output logic valid_o,
  output logic [7:0] byte_o,
  output logic [7:0] err_o,
  output logic busy_o
);
  logic [7:0] left_r;
  logic [7:0] seq_r;
  assign busy_o = left_r != 8'h00;
  assign valid_o = busy_o;
  // idle byte line shows the inverse of the last byte, error line a fixed 0xfe
  assign byte_o = busy_o ? seq_r : ~(seq_r - 8'h01);
  assign err_o = busy_o ? {seq_r[2:0], 5'h01} : 8'hfe;
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      left_r <= 8'h00;
      seq_r <= 8'h00;
    end else if (go_i) begin
      left_r <= n_i;
    end else if (busy_o && ready_i) begin
      left_r <= left_r - 8'h01;
      seq_r <= seq_r + 8'h01;
    end
  end
endmodule : ucrx_rx_src
`default_nettype wire

/* File: test/tb_top.sv */
// testbench for the uart channel block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; $display("wrong value t=%0t compare mismatch", $time); end end
module tb_top;
  logic clk_sys_i = 0, sys_rst_i = 1, rd = 0, wr = 0, ir = 0, go = 0;
  logic rvalid, rx_v, rx_r, irq, sync, busy;
  logic [11:0] addr = 0;
  logic [7:0] wd = 0, n = 0, e = 0, rx_b, rx_e;
  logic [15:0] d, rdata;
  int fails = 0, cmp_count = 0, cyc = 0;
  always #2 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
  end
  ucrx_channel dut_u (.clk_sys_i, .sys_rst_i, .bus_rd_i(rd), .bus_wr_i(wr), .bus_addr_i(addr),
    .bus_wdata_i(wd), .bus_rdata_o(rdata), .bus_rvalid_o(rvalid), .rx_valid_i(rx_v), .rx_byte_i(rx_b),
    .rx_err_i(rx_e), .rx_ready_o(rx_r), .modem_in_i(4'ha), .infrared_enable_pin_i(ir), .tx_o(),
    .rts_n_o(), .dtr_n_o(), .eeprom_serial_clock_o(), .eeprom_chip_select_o(),
    .eeprom_serial_out_o(), .irq_o(irq), .unload_synced_o(sync));
  ucrx_rx_src src_u (.clk_sys_i, .sys_rst_i, .go_i(go), .n_i(n), .ready_i(rx_r), .valid_o(rx_v),
    .byte_o(rx_b), .err_o(rx_e), .busy_o(busy));
  task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    #1;
    {rd, wr, addr, wd} = {!w, w, a, v};
    @(posedge clk_sys_i);
    #1;
    {rd, wr} = 2'b00;
    d = rdata;
  endtask : acc
  task automatic rc(input logic [11:0] a, input logic [15:0] x);
    acc(1'b0, a, 8'h00);
    `CHK(d, x)
  endtask : rc
  task automatic feed(input logic [7:0] k);
    {go, n} = {1'b1, k};
    @(posedge clk_sys_i);
    #1;
    go = 0;
    while (busy) @(posedge clk_sys_i);
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask : feed
  task automatic unload(input int k);
    repeat (k) begin
      rc(12'h180, {e[2:0], 5'h01, e});
      e++;
    end
  endtask : unload
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (3) @(posedge clk_sys_i);
    #1;
    sys_rst_i = 0;
    rc(12'h0a1, 16'h0001);
    rc(12'h0a2, 16'h0060);
    rc(12'h0a4, 16'h00ff);
    rc(12'h0a5, 16'h0000);
    rc(12'h0a3, 16'h00a0);
    rc(12'h082, 16'h0000);
    rc(12'h0ff, 16'h0000);
    acc(1'b1, 12'h0a0, 8'h03);
    feed(2);
    `CHK(irq, 1'b0)
    feed(1);
    `CHK(irq, 1'b1)
    acc(1'b0, 12'h080, 8'h00);
    `CHK(d[0], 1'b1)
    acc(1'b1, 12'h0a0, 8'h41);
    rc(12'h08d, 16'h005a);
    `CHK(irq, 1'b1)
    `CHK(sync, 1'b1)
    unload(3);
    rc(12'h180, 16'h6000);
    `CHK(irq, 1'b0)
    {go, n} = {1'b1, 8'd20};
    @(posedge clk_sys_i);
    #1;
    go = 0;
    repeat (40) @(posedge clk_sys_i);
    #1;
    `CHK(rx_r, 1'b0)
    rc(12'h0a4, 16'h00ff);
    `CHK(sync, 1'b0)
    rc(12'h08d, 16'h005a);
    unload(20);
    rc(12'h180, 16'h6000);
    ir = 1;
    repeat (3) @(posedge clk_sys_i);
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
